// File: imfc_defines.svh
// Purpose: Constants for the idle mode and pixel format command block
// Assumes: Byte-wide command stream from the host interface
// Notes: Codes, field positions and reset values
`ifndef IMFC_DEFINES_SVH
`define IMFC_DEFINES_SVH
`define IMFC_CMD_IDLE_OFF 8'h38
`define IMFC_CMD_IDLE_ON 8'h39
`define IMFC_CMD_PIXFMT 8'h3a
`define IMFC_PIXFMT_RST 8'h66
`define IMFC_VID_MSB 6
`define IMFC_VID_LSB 4
`define IMFC_SYS_MSB 2
`define IMFC_SYS_LSB 0
`define IMFC_FMT_16 3'h5
`define IMFC_FMT_18 3'h6
`endif

// File: imfc_pkg.sv
// Purpose: Types for the idle mode and pixel format command block
// Assumes: Nothing beyond the defines header
// Notes: One-hot decoder states
package imfc_pkg;
	typedef enum logic [1:0] {
		IMFC_ST_CMD = 2'b01,
		IMFC_ST_PARAM = 2'b10
	} imfc_state_t;
endpackage : imfc_pkg

// File: imfc_pix_if.sv
// Purpose: Pixel path signals between decoder and colour reducer
// Assumes: One clock domain
// Notes: Top keeps plain ports
`timescale 1ns/1ps
`default_nettype none
interface imfc_pix_if;
	logic idle;
	logic frame_start;
	logic [17:0] pix_in;
	logic [17:0] pix_out;
	modport ctrl (output idle, output frame_start, output pix_in,
		input pix_out);
	modport red (input idle, input frame_start, input pix_in,
		output pix_out);
endinterface : imfc_pix_if
`default_nettype wire

// File: imfc_color_reduce.sv
// Purpose: Reduces scan pixels to eight colours in idle state
// Assumes: Pixel is R[17:12] G[11:6] B[5:0]
// Notes: Idle level latched at frame start only
`timescale 1ns/1ps
`default_nettype none
module imfc_color_reduce (
	input wire logic clk,
	input wire logic resetn,
	imfc_pix_if.red px
);
	logic idle_frame_q;
	logic idle_frame_d;
	logic [17:0] pix_q;
	logic [17:0] pix_d;

	always_comb begin
		idle_frame_d = idle_frame_q;
		// Mode change lands on a frame boundary, never mid-frame
		if (px.frame_start) begin // [RULE6]
			idle_frame_d = px.idle;
		end
		pix_d = px.pix_in; // [RULE13]
		if (idle_frame_q) begin // [RULE2]
			pix_d = {{6{px.pix_in[17]}}, {6{px.pix_in[11]}},
				{6{px.pix_in[5]}}};
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			idle_frame_q <= 1'b0;
			pix_q <= 18'h0_0000;
		end else begin
			idle_frame_q <= idle_frame_d;
			pix_q <= pix_d;
		end
	end

	assign px.pix_out = pix_q;

	a_reduce_msb: assert property ( // [RULE2]
		@(posedge clk) disable iff (!resetn)
		idle_frame_q |=> pix_q == {{6{$past(px.pix_in[17])}},
		{6{$past(px.pix_in[11])}}, {6{$past(px.pix_in[5])}}})
		else $error("idle pixel not reduced");
	a_full_pass: assert property ( // [RULE13]
		@(posedge clk) disable iff (!resetn)
		!idle_frame_q |=> pix_q == $past(px.pix_in))
		else $error("full colour pixel altered");
	a_frame_only: assert property ( // [RULE6]
		@(posedge clk) disable iff (!resetn)
		!px.frame_start |=> $stable(idle_frame_q))
		else $error("colour mode changed mid-frame");
endmodule : imfc_color_reduce
`default_nettype wire

// File: imfc_top.sv
// Purpose: Idle mode and pixel format command handling
// Assumes: Host bytes arrive as one-cycle strobes with a command flag
// Notes: Overview below
// Overview of operation
// [RULE1] Command 39h enters idle state; it has no parameter bytes.
// [RULE2] Idle shows eight colours from the MSB of each of R, G, B.
// [RULE3] Idle refresh uses the eight-colour frame rate.
// [RULE4] Only command 38h leaves the idle state.
// [RULE5] Idle-on while already idle changes nothing.
// [RULE6] Colour state changes without visible artefact.
// [RULE7] Command 3Ah takes one byte; bits 6..4 set video port format.
// [RULE8] Bits 2..0 set host port format; bits 7 and 3 ignored.
// [RULE9] Code 101 is 16 bpp, 110 is 18 bpp, other codes reserved.
// [RULE10] Hardware reset sets format to 66h; software reset keeps it.
// [RULE11] Host using the video port selects the serial system port; this block has no port select logic.
// [RULE12] Format change shows nothing until frame memory is written.
// [RULE13] Outside idle: full colour depth and normal frame rate.
// [RULE14] Commands accepted in every state; resets clear idle.
`include "imfc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module imfc_top (
	input wire logic clk,
	input wire logic resetn,
	input wire logic sw_reset,
	input wire logic byte_valid,
	input wire logic byte_is_cmd,
	input wire logic [7:0] byte_data,
	input wire logic frame_start,
	input wire logic mem_write,
	input wire logic [17:0] scan_pixel,
	output logic idle_mode,
	output logic rate_sel_8color,
	output logic [7:0] pixel_format_config,
	output logic [2:0] vid_fmt,
	output logic [2:0] sys_fmt,
	output logic fmt_reserved,
	output logic [17:0] panel_pixel
);
	imfc_pkg::imfc_state_t state_q;
	imfc_pkg::imfc_state_t state_d;
	logic idle_q;
	logic idle_d;
	logic rate_q;
	logic rate_d;
	logic [7:0] fmt_q;
	logic [7:0] fmt_d;
	logic [2:0] vid_q;
	logic [2:0] vid_d;
	logic [2:0] sys_q;
	logic [2:0] sys_d;
	logic resv_q;
	logic resv_d;
	logic cmd_stb;
	logic par_stb;

	imfc_pix_if px ();

	assign cmd_stb = byte_valid && byte_is_cmd;
	assign par_stb = byte_valid && !byte_is_cmd;

	// Decoder and registers; no sleep gating anywhere
	always_comb begin
		state_d = state_q;
		idle_d = idle_q;
		fmt_d = fmt_q;
		if (sw_reset) begin
			idle_d = 1'b0; // [RULE14]
			state_d = imfc_pkg::IMFC_ST_CMD;
		end else if (cmd_stb) begin // [RULE14]
			state_d = imfc_pkg::IMFC_ST_CMD;
			case (byte_data)
			`IMFC_CMD_IDLE_ON: begin
				idle_d = 1'b1; // [RULE1] [RULE5]
			end
			`IMFC_CMD_IDLE_OFF: begin
				idle_d = 1'b0; // [RULE4]
			end
			`IMFC_CMD_PIXFMT: begin
				state_d = imfc_pkg::IMFC_ST_PARAM; // [RULE7]
			end
			default: begin
				state_d = imfc_pkg::IMFC_ST_CMD;
			end
			endcase
		end else if (par_stb) begin
			case (state_q)
			imfc_pkg::IMFC_ST_PARAM: begin
				// Don't-care bits stored as zero
				fmt_d = {1'b0, byte_data[`IMFC_VID_MSB:`IMFC_VID_LSB],
					1'b0, byte_data[`IMFC_SYS_MSB:`IMFC_SYS_LSB]};
				state_d = imfc_pkg::IMFC_ST_CMD; // [RULE7] [RULE8]
			end
			default: begin
				state_d = imfc_pkg::IMFC_ST_CMD;
			end
			endcase
		end
	end

	// Active format follows the register only on a memory write
	always_comb begin
		vid_d = vid_q;
		sys_d = sys_q;
		if (mem_write) begin // [RULE12]
			vid_d = fmt_q[`IMFC_VID_MSB:`IMFC_VID_LSB];
			sys_d = fmt_q[`IMFC_SYS_MSB:`IMFC_SYS_LSB];
		end
		resv_d = !((fmt_q[6:4] == `IMFC_FMT_16 ||
			fmt_q[6:4] == `IMFC_FMT_18) &&
			(fmt_q[2:0] == `IMFC_FMT_16 ||
			fmt_q[2:0] == `IMFC_FMT_18)); // [RULE9]
		rate_d = rate_q;
		if (frame_start) begin
			rate_d = idle_q; // [RULE3] [RULE13]
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= imfc_pkg::IMFC_ST_CMD;
			idle_q <= 1'b0;
			fmt_q <= `IMFC_PIXFMT_RST; // [RULE10]
			vid_q <= `IMFC_FMT_18;
			sys_q <= `IMFC_FMT_18;
			resv_q <= 1'b0;
			rate_q <= 1'b0;
		end else begin
			state_q <= state_d;
			idle_q <= idle_d;
			fmt_q <= fmt_d;
			vid_q <= vid_d;
			sys_q <= sys_d;
			resv_q <= resv_d;
			rate_q <= rate_d;
		end
	end

	assign px.idle = idle_q;
	assign px.frame_start = frame_start;
	assign px.pix_in = scan_pixel;

	imfc_color_reduce u_reduce (
		.clk(clk),
		.resetn(resetn),
		.px(px)
	);

	assign idle_mode = idle_q;
	assign rate_sel_8color = rate_q;
	assign pixel_format_config = fmt_q;
	assign vid_fmt = vid_q;
	assign sys_fmt = sys_q;
	assign fmt_reserved = resv_q;
	assign panel_pixel = px.pix_out;

	sequence s_fmt_cmd;
		cmd_stb && byte_data == `IMFC_CMD_PIXFMT && !sw_reset;
	endsequence
	sequence s_fmt_par;
		par_stb && !sw_reset;
	endsequence
	sequence s_fmt_gap;
		!byte_valid && !sw_reset;
	endsequence

	a_idle_on_cmd: assert property ( // [RULE1]
		@(posedge clk) disable iff (!resetn)
		cmd_stb && !sw_reset && byte_data == `IMFC_CMD_IDLE_ON
		|=> idle_q) else $error("idle-on not taken");
	a_idle_stays: assert property ( // [RULE4]
		@(posedge clk) disable iff (!resetn)
		idle_q && !(cmd_stb && byte_data == `IMFC_CMD_IDLE_OFF)
		&& !sw_reset |=> idle_q)
		else $error("idle left without 38h");
	a_idle_reon: assert property ( // [RULE5]
		@(posedge clk) disable iff (!resetn)
		idle_q && cmd_stb && byte_data == `IMFC_CMD_IDLE_ON && !sw_reset
		|=> idle_q && $stable(fmt_q))
		else $error("repeat idle-on changed state");
	a_idle_off_cmd: assert property ( // [RULE4]
		@(posedge clk) disable iff (!resetn)
		cmd_stb && !sw_reset && byte_data == `IMFC_CMD_IDLE_OFF
		|=> !idle_q) else $error("idle-off not taken");
	a_fmt_param: assert property ( // [RULE7]
		@(posedge clk) disable iff (!resetn)
		s_fmt_cmd ##1 s_fmt_gap ##1 s_fmt_par
		|=> fmt_q == {1'b0, $past(byte_data[6:4]), 1'b0,
		$past(byte_data[2:0])})
		else $error("format byte not stored");
	a_stray_par: assert property ( // [RULE7]
		@(posedge clk) disable iff (!resetn)
		par_stb && state_q != imfc_pkg::IMFC_ST_PARAM |=> $stable(fmt_q))
		else $error("stray format byte stored");
	a_fmt_swrst: assert property ( // [RULE10]
		@(posedge clk) disable iff (!resetn)
		sw_reset |=> $stable(fmt_q) && !idle_q)
		else $error("software reset disturbed state");
	a_fmt_hold: assert property ( // [RULE12]
		@(posedge clk) disable iff (!resetn)
		!mem_write |=> $stable(vid_q) && $stable(sys_q))
		else $error("format applied without write");
	a_rate_sel: assert property ( // [RULE3]
		@(posedge clk) disable iff (!resetn)
		frame_start |=> rate_q == $past(idle_q))
		else $error("frame rate not following idle");
	a_resv_flag: assert property ( // [RULE9]
		@(posedge clk) disable iff (!resetn)
		fmt_q == `IMFC_PIXFMT_RST && $stable(fmt_q) |=> !resv_q)
		else $error("valid format flagged reserved");
endmodule : imfc_top
`default_nettype wire

// File: imfc_host_model.sv
// Purpose: Host model sending command and parameter bytes
// Assumes: Bytes change 1 ns after the rising edge
// Notes: Released data shows the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module imfc_host_model (
	input wire logic clk,
	output logic byte_valid,
	output logic byte_is_cmd,
	output logic [7:0] byte_data
);
	initial begin
		byte_valid = 1'b0;
		byte_is_cmd = 1'b0;
		byte_data = 8'h00;
	end
	// Serial system port taken as selected while video port used
	// One strobed byte; legal codes unless a scenario asks
	task automatic send(input logic c, input logic [7:0] d);
		@(posedge clk);
		#1;
		byte_valid = 1'b1;
		byte_is_cmd = c;
		byte_data = d;
		@(posedge clk);
		#1;
		byte_valid = 1'b0;
		byte_data = ~d;
	endtask : send
endmodule : imfc_host_model
`default_nettype wire

// File: imfc_top_bench.sv
// Purpose: Self-checking bench for the idle and format commands
// Assumes: Inputs move 1 ns after the rising edge
// Notes: Expected notes are queued and compared by a watcher
`include "imfc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module imfc_top_bench;
	logic clk, resetn, sw_reset, frame_start, mem_write, chk;
	logic byte_valid, byte_is_cmd, idle_mode, rate_sel_8color;
	logic fmt_reserved, idle, rate;
	logic [7:0] byte_data, pixel_format_config, cfg;
	logic [2:0] vid_fmt, sys_fmt, vid, sys;
	logic [17:0] scan_pixel, panel_pixel;
	logic [31:0] rnd;
	logic [34:0] q[$];
	int n_errors, n_tests;
	imfc_host_model host (.clk(clk), .byte_valid(byte_valid),
		.byte_is_cmd(byte_is_cmd), .byte_data(byte_data));
	imfc_top dut (.clk(clk), .resetn(resetn), .sw_reset(sw_reset),
		.byte_valid(byte_valid), .byte_is_cmd(byte_is_cmd),
		.byte_data(byte_data), .frame_start(frame_start),
		.mem_write(mem_write), .scan_pixel(scan_pixel),
		.idle_mode(idle_mode), .rate_sel_8color(rate_sel_8color),
		.pixel_format_config(pixel_format_config), .vid_fmt(vid_fmt),
		.sys_fmt(sys_fmt), .fmt_reserved(fmt_reserved),
		.panel_pixel(panel_pixel));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic bad(input logic [2:0] f);
		return f != `IMFC_FMT_16 && f != `IMFC_FMT_18;
	endfunction : bad
	task automatic cmp(input logic [34:0] e, input logic [34:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("Error at %0t: expected %h got %h", $time, e, g);
		end
	endtask : cmp
	task automatic give_verdict();
		if (n_errors == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : give_verdict
	task automatic note();
		logic [17:0] p;
		rnd = lfsr(rnd);
		scan_pixel = rnd[17:0];
		p = rate ? {{6{rnd[17]}}, {6{rnd[11]}}, {6{rnd[5]}}} : rnd[17:0];
		repeat (2) @(posedge clk);
		#1;
		q.push_back({idle, rate, bad(cfg[6:4]) | bad(cfg[2:0]), cfg, vid,
			sys, p});
		chk = 1'b1;
		@(posedge clk);
		#1;
		chk = 1'b0;
	endtask : note
	task automatic cmd(input logic [7:0] c);
		host.send(1'b1, c);
		if (c == `IMFC_CMD_IDLE_ON) idle = 1'b1;
		if (c == `IMFC_CMD_IDLE_OFF) idle = 1'b0;
	endtask : cmd
	task automatic fmt(input logic [7:0] d);
		host.send(1'b1, `IMFC_CMD_PIXFMT);
		host.send(1'b0, d);
		cfg = d & 8'h77;
	endtask : fmt
	task automatic tick(input logic f, input logic w, input logic r);
		@(posedge clk);
		#1;
		{frame_start, mem_write, sw_reset} = {f, w, r};
		@(posedge clk);
		#1;
		{frame_start, mem_write, sw_reset} = 3'h0;
		if (r) idle = 1'b0;
		if (f) rate = idle;
		if (w) {vid, sys} = {cfg[6:4], cfg[2:0]};
	endtask : tick
	always @(posedge clk) begin
		if (chk === 1'b1) begin
			cmp(q.pop_front(), {idle_mode, rate_sel_8color, fmt_reserved,
				pixel_format_config, vid_fmt, sys_fmt, panel_pixel});
		end
	end
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		#(40 * 3000);
		n_errors++;
		give_verdict();
	end
	initial begin
		{resetn, sw_reset, frame_start, mem_write, chk} = 5'h00;
		{idle, rate, cfg, vid, sys} = {2'h0, 8'h66, 6'h36};
		scan_pixel = 18'h0_0000;
		rnd = 32'hc845_0ed3;
		repeat (5) @(posedge clk);
		#1;
		resetn = 1'b1;
		note();
		for (int i = 0; i < 8; i++) begin
			fmt({rnd[7], i[2:0], rnd[3], ~i[2:0]});
			note();
			tick(1'b0, 1'b1, 1'b0);
			note();
		end
		cmd(`IMFC_CMD_IDLE_ON);
		note();
		tick(1'b1, 1'b0, 1'b0);
		note();
		cmd(`IMFC_CMD_IDLE_ON);
		cmd(8'h37);
		note();
		cmd(`IMFC_CMD_IDLE_OFF);
		note();
		tick(1'b1, 1'b0, 1'b0);
		note();
		host.send(1'b1, `IMFC_CMD_PIXFMT);
		host.send(1'b1, 8'h37);
		host.send(1'b0, 8'h11);
		note();
		cmd(`IMFC_CMD_IDLE_ON);
		tick(1'b1, 1'b0, 1'b0);
		fmt(8'h56);
		tick(1'b0, 1'b0, 1'b1);
		tick(1'b1, 1'b0, 1'b0);
		note();
		resetn = 1'b0;
		@(posedge clk);
		#1;
		resetn = 1'b1;
		{idle, rate, cfg, vid, sys} = {2'h0, 8'h66, 6'h36};
		note();
		give_verdict();
	end
endmodule : imfc_top_bench
`default_nettype wire
